// ### pbp_colour_width.sv
// colour width mapping between the host bus and internal data
`timescale 1ns/1ps
module pbp_colour_width
  import pbp_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int NARROW_W = 6
) (
  input wire logic wide_mode,
  input wire logic is_colour,
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_value,
  output logic [DATA_W-1:0] bus_out
);

  // narrow colour: top bits dropped on writes, zero on reads
  always_comb begin
    if (is_colour && !wide_mode) begin
      wr_data = {{(DATA_W-NARROW_W){1'b0}}, bus_in[NARROW_W-1:0]};
      bus_out = {{(DATA_W-NARROW_W){1'b0}}, rd_value[NARROW_W-1:0]};
    end else begin
      wr_data = bus_in;
      bus_out = rd_value;
    end
  end

endmodule : pbp_colour_width

// ### pbp_defs.svh
// constants for the palette host bus port
`ifndef PBP_DEFS_SVH
`define PBP_DEFS_SVH

`define PBP_DATA_W 8
`define PBP_SEL_W 3
`define PBP_COLOUR_MSB_WIDE 7
`define PBP_COLOUR_MSB_NARROW 5
`define PBP_NARROW_W 6
`define PBP_COLOUR_TARGETS 8'h02
`define PBP_BUS_RESET 8'h00
`define PBP_SEL_RESET 3'h0

`endif

// ### pbp_host_model.sv
// host processor model on the far side of the palette port
`timescale 1ns/1ps
module pbp_host_model (
  input wire logic mclk,
  input wire logic [7:0] dev_bus_out,
  input wire logic dev_oe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] target_select,
  output logic [7:0] bus_seen
);
  logic [7:0] host_drive;
  logic host_en;
  logic [7:0] float_pat = 8'h5a;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    target_select = 3'h0;
    host_drive = 8'h00;
    host_en = 1'b0;
  end
  // released bus wanders every cycle
  always @(posedge mclk) float_pat <= ~float_pat;
  assign bus_seen = (!dev_oe_n && host_en) ? 8'hxx : !dev_oe_n ? dev_bus_out : host_en ? host_drive : float_pat;
  task automatic host_write(input logic [2:0] sel, input logic [7:0] data);
    @(negedge mclk);
    wr_n = 1'b0;
    target_select = sel;
    host_drive = ~data;
    host_en = 1'b1;
    @(negedge mclk);
    target_select = ~sel;
    @(negedge mclk);
    host_drive = data;
    @(negedge mclk);
    wr_n = 1'b1;
    @(negedge mclk);
    host_en = 1'b0;
  endtask : host_write
  task automatic host_read(input logic [2:0] sel, output logic [7:0] got);
    @(negedge mclk);
    rd_n = 1'b0;
    target_select = sel;
    @(negedge mclk);
    target_select = ~sel;
    repeat (3) @(negedge mclk);
    got = bus_seen;
    rd_n = 1'b1;
  endtask : host_read
  // both strobes low on purpose
  task automatic host_clash(input logic [2:0] sel);
    @(negedge mclk);
    wr_n = 1'b0;
    rd_n = 1'b0;
    target_select = sel;
    repeat (2) @(negedge mclk);
    wr_n = 1'b1;
    rd_n = 1'b1;
  endtask : host_clash
endmodule : pbp_host_model

// ### pbp_host_port.sv
// strobe-driven host port of the colour palette converter
// Behaviour
// - write data is taken from the bus at the deasserting edge of the write strobe.
// - the target select code is taken at the asserting edge of the write strobe.
// - a read happens only while the read strobe is low and data is returned during it.
// - the target select code is taken at the asserting edge of the read strobe.
// - the captured select code names the target and kind of each access.
// - all transfers use one 8-bit two-way data bus with bit 0 least significant.
// - the width pin picks 8-bit (high) or 6-bit (low) colour transfers.
// - in 8-bit width bus bit 7 is the colour msb for reads and writes.
// - in 6-bit width bus bit 5 is the colour msb for reads and writes.
// - in 6-bit width bits 6 and 7 are ignored on colour writes and read as zero.
`timescale 1ns/1ps
`include "pbp_defs.svh"
module pbp_host_port
  import pbp_pkg::*;
#(
  parameter int DATA_W = `PBP_DATA_W,
  parameter int SEL_W = `PBP_SEL_W,
  parameter int NARROW_W = `PBP_NARROW_W,
  parameter logic [7:0] COLOUR_TARGETS = `PBP_COLOUR_TARGETS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [SEL_W-1:0] target_select,
  input wire logic [DATA_W-1:0] host_data_bus_in,
  output logic [DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  input wire logic width_8bit,
  output logic wr_valid,
  output logic [SEL_W-1:0] wr_target,
  output logic [DATA_W-1:0] wr_data,
  output logic rd_start,
  output logic [SEL_W-1:0] rd_target,
  input wire logic [DATA_W-1:0] rd_data,
  output logic rd_done,
  output logic overlap_error
);

  pbp_state_t state_reg;
  logic rd_n_q_reg;
  logic wr_n_q_reg;
  logic [SEL_W-1:0] sel_reg;
  logic wide_reg;
  logic [DATA_W-1:0] wr_hold_reg;
  logic wr_valid_reg;
  logic [SEL_W-1:0] wr_target_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic rd_start_reg;
  logic rd_done_reg;
  logic [DATA_W-1:0] bus_out_reg;
  logic bus_oe_n_reg;
  logic overlap_reg;

  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic overlap;
  logic sel_is_colour;
  logic wide_now;
  logic [DATA_W-1:0] mapped_wr;
  logic [DATA_W-1:0] mapped_rd;

  assign overlap = !rd_n && !wr_n;
  assign wr_fall = wr_n_q_reg && !wr_n;
  assign wr_rise = !wr_n_q_reg && wr_n;
  assign rd_fall = rd_n_q_reg && !rd_n;
  assign rd_rise = !rd_n_q_reg && rd_n;
  assign sel_is_colour = COLOUR_TARGETS[sel_reg];
  assign wide_now = wide_reg;

  pbp_colour_width #(
    .DATA_W(DATA_W),
    .NARROW_W(NARROW_W)
  ) u_width (
    .wide_mode(wide_now),
    .is_colour(sel_is_colour),
    .bus_in(wr_hold_reg),
    .wr_data(mapped_wr),
    .rd_value(rd_data),
    .bus_out(mapped_rd)
  );

  // strobe history for edge detection
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_n_q_reg <= 1'b1;
      wr_n_q_reg <= 1'b1;
    end else begin
      rd_n_q_reg <= rd_n;
      wr_n_q_reg <= wr_n;
    end
  end

  // access sequencing
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= PBP_IDLE;
    end else if (overlap) begin
      state_reg <= PBP_IDLE;
    end else begin
      unique case (state_reg)
        PBP_IDLE: begin
          if (wr_fall) begin
            state_reg <= PBP_WRITE;
          end else if (rd_fall) begin
            state_reg <= PBP_READ;
          end
        end
        PBP_WRITE: begin
          if (wr_n) begin
            state_reg <= PBP_IDLE;
          end
        end
        PBP_READ: begin
          if (rd_n) begin
            state_reg <= PBP_IDLE;
          end
        end
        default: begin
          state_reg <= PBP_IDLE;
        end
      endcase
    end
  end

  // select code and width caught at the asserting edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_reg <= `PBP_SEL_RESET;
      wide_reg <= 1'b0;
    end else if (state_reg == PBP_IDLE && !overlap && (wr_fall || rd_fall)) begin
      sel_reg <= target_select;
      wide_reg <= width_8bit;
    end
  end

  // last bus value seen while the write strobe is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_hold_reg <= `PBP_BUS_RESET;
    end else if (!wr_n) begin
      wr_hold_reg <= host_data_bus_in;
    end
  end

  // write completion on the deasserting edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_valid_reg <= 1'b0;
      wr_target_reg <= `PBP_SEL_RESET;
      wr_data_reg <= `PBP_BUS_RESET;
    end else begin
      wr_valid_reg <= 1'b0;
      if (state_reg == PBP_WRITE && wr_rise && rd_n) begin
        wr_valid_reg <= 1'b1;
        wr_target_reg <= sel_reg;
        wr_data_reg <= mapped_wr;
      end
    end
  end

  // read start and end pulses
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_start_reg <= 1'b0;
      rd_done_reg <= 1'b0;
    end else begin
      rd_start_reg <= state_reg == PBP_IDLE && rd_fall && wr_n;
      rd_done_reg <= state_reg == PBP_READ && rd_rise;
    end
  end

  // bus drive during reads
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_out_reg <= `PBP_BUS_RESET;
      bus_oe_n_reg <= 1'b1;
    end else if (state_reg == PBP_READ && !rd_n && wr_n) begin
      bus_out_reg <= mapped_rd;
      bus_oe_n_reg <= 1'b0;
    end else begin
      bus_out_reg <= `PBP_BUS_RESET;
      bus_oe_n_reg <= 1'b1;
    end
  end

  // both strobes low at once
  always_ff @(posedge mclk) begin
    if (reset) begin
      overlap_reg <= 1'b0;
    end else begin
      overlap_reg <= overlap;
    end
  end

  assign host_data_bus_out = bus_out_reg;
  assign host_data_bus_oe_n = bus_oe_n_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_target = wr_target_reg;
  assign wr_data = wr_data_reg;
  assign rd_start = rd_start_reg;
  assign rd_target = sel_reg;
  assign rd_done = rd_done_reg;
  assign overlap_error = overlap_reg;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_write_data_edge: assert property (
    (state_reg == PBP_WRITE && !wr_n && rd_n) ##1 (wr_n && rd_n)
      |=> wr_valid && wr_data[NARROW_W-1:0] == $past(wr_hold_reg[NARROW_W-1:0]))
    else $error("write data not delivered after write strobe release");

  a_write_sel_edge: assert property (
    (state_reg == PBP_IDLE && wr_fall && rd_n) |=> sel_reg == $past(target_select))
    else $error("select code not caught at write strobe assertion");

  a_overlap_flag: assert property (
    (!rd_n && !wr_n) |=> overlap_error && state_reg == PBP_IDLE)
    else $error("strobe overlap not flagged");

  a_read_drive_time: assert property (
    (state_reg == PBP_READ && !rd_n && wr_n) |=> !host_data_bus_oe_n)
    else $error("bus not driven during read");

  a_read_sel_edge: assert property (
    (state_reg == PBP_IDLE && rd_fall && wr_n)
      |=> rd_start && rd_target == $past(target_select) ##1 !rd_start)
    else $error("select code not caught at read strobe assertion");

  a_write_target: assert property (
    wr_valid |-> wr_target == sel_reg)
    else $error("write target differs from captured select");

  a_wide_msb: assert property (
    (state_reg == PBP_READ && !rd_n && wr_n && wide_reg)
      |=> host_data_bus_out[DATA_W-1] == $past(rd_data[DATA_W-1]))
    else $error("wide read lost top bit");

  a_narrow_msb: assert property (
    (state_reg == PBP_READ && !rd_n && wr_n && !wide_reg)
      |=> host_data_bus_out[NARROW_W-1] == $past(rd_data[NARROW_W-1]))
    else $error("narrow read lost bit five");

  a_narrow_zero: assert property (
    (wr_valid && COLOUR_TARGETS[wr_target] && !wide_reg)
      |-> wr_data[DATA_W-1:NARROW_W] == '0)
    else $error("narrow colour write kept upper bits");

  a_narrow_read_zero: assert property (
    (!host_data_bus_oe_n && COLOUR_TARGETS[sel_reg] && !wide_reg)
      |-> host_data_bus_out[DATA_W-1:NARROW_W] == '0)
    else $error("narrow colour read drove upper bits");

  a_idle_release: assert property (
    (rd_n && state_reg != PBP_READ) |=> host_data_bus_oe_n[*2])
    else $error("bus driven outside a read");

  c_write_cycle: cover property (wr_fall ##[1:20] wr_valid);
  c_read_cycle: cover property (rd_start ##[1:20] rd_done);
  c_narrow_colour_write: cover property (wr_valid && !wide_reg && COLOUR_TARGETS[wr_target]);
  c_overlap_seen: cover property (overlap_error);

endmodule : pbp_host_port

// ### pbp_pkg.sv
// types for the palette host bus port
package pbp_pkg;

  typedef enum logic [2:0] {
    PBP_IDLE  = 3'b001,
    PBP_WRITE = 3'b010,
    PBP_READ  = 3'b100
  } pbp_state_t;

  typedef logic [7:0] pbp_byte_t;
  typedef logic [2:0] pbp_sel_t;

endpackage : pbp_pkg

// ### tb_top.sv
// self-checking bench of the palette host bus port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb_top;
  import pbp_pkg::*;
  logic mclk;
  logic reset;
  logic width_8bit;
  logic rd_n;
  logic wr_n;
  logic oe_n;
  logic wr_valid;
  logic rd_start;
  logic rd_done;
  logic overlap_error;
  int ovl_cnt;
  pbp_sel_t target_select;
  pbp_sel_t wr_target;
  pbp_sel_t rd_target;
  pbp_byte_t bus_seen;
  pbp_byte_t bus_out;
  pbp_byte_t wr_data;
  pbp_byte_t rd_data;
  int bad_count;
  int checked;
  int cycles;
  int wr_cnt;
  int rs_cnt;
  int rd_cnt;
  pbp_host_port uut (.mclk(mclk), .reset(reset), .rd_n(rd_n), .wr_n(wr_n), .target_select(target_select),
    .host_data_bus_in(bus_seen), .host_data_bus_out(bus_out), .host_data_bus_oe_n(oe_n),
    .width_8bit(width_8bit), .wr_valid(wr_valid), .wr_target(wr_target), .wr_data(wr_data),
    .rd_start(rd_start), .rd_target(rd_target), .rd_data(rd_data), .rd_done(rd_done),
    .overlap_error(overlap_error));
  pbp_host_model host (.mclk(mclk), .dev_bus_out(bus_out), .dev_oe_n(oe_n), .rd_n(rd_n), .wr_n(wr_n),
    .target_select(target_select), .bus_seen(bus_seen));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (wr_valid === 1'b1) wr_cnt++;
    if (rd_start === 1'b1) rs_cnt++;
    if (rd_done === 1'b1) rd_cnt++;
    if (overlap_error === 1'b1) ovl_cnt++;
    if (cycles > 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic do_write(input pbp_sel_t sel, input pbp_byte_t data, input logic w8, input pbp_byte_t exp);
    int n;
    n = wr_cnt;
    width_8bit = w8;
    host.host_write(sel, data);
    `CHK("oe_n in write", 1'b1, oe_n)
    repeat (3) @(negedge mclk);
    `CHK("wr pulses", n + 1, wr_cnt)
    `CHK("wr_target", sel, wr_target)
    `CHK("wr_data", exp, wr_data)
  endtask : do_write
  task automatic do_read(input pbp_sel_t sel, input pbp_byte_t rdv, input logic w8, input pbp_byte_t exp);
    pbp_byte_t got;
    int n;
    int m;
    n = rs_cnt;
    m = rd_cnt;
    rd_data = rdv;
    width_8bit = w8;
    host.host_read(sel, got);
    `CHK("rd_start", n + 1, rs_cnt)
    `CHK("rd_target", sel, rd_target)
    `CHK("read bus", exp, got)
    repeat (2) @(negedge mclk);
    `CHK("oe_n release", 1'b1, oe_n)
    `CHK("rd_done", m + 1, rd_cnt)
  endtask : do_read
  task automatic do_clash();
    int n;
    int r;
    int o;
    n = wr_cnt;
    r = rs_cnt;
    o = ovl_cnt;
    host.host_clash(3'h1);
    repeat (3) @(negedge mclk);
    `CHK("overlap cycles", o + 2, ovl_cnt)
    `CHK("no write", n, wr_cnt)
    `CHK("no read start", r, rs_cnt)
    `CHK("oe_n clash", 1'b1, oe_n)
  endtask : do_clash
  initial begin
    reset = 1'b1;
    width_8bit = 1'b1;
    rd_data = 8'h00;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    `CHK("oe_n after reset", 1'b1, oe_n)
    `CHK("overlap after reset", 1'b0, overlap_error)
    do_write(3'h1, 8'ha5, 1'b1, 8'ha5);
    do_write(3'h1, 8'hff, 1'b0, 8'h3f);
    do_write(3'h1, 8'h9c, 1'b0, 8'h1c);
    do_write(3'h0, 8'hff, 1'b0, 8'hff);
    do_write(3'h7, 8'h81, 1'b1, 8'h81);
    do_read(3'h1, 8'hc7, 1'b0, 8'h07);
    do_read(3'h1, 8'hc7, 1'b1, 8'hc7);
    do_read(3'h1, 8'h2a, 1'b0, 8'h2a);
    do_read(3'h0, 8'hc7, 1'b0, 8'hc7);
    do_read(3'h6, 8'h5a, 1'b1, 8'h5a);
    do_clash();
    do_write(3'h2, 8'h3c, 1'b1, 8'h3c);
    print_verdict();
  end
endmodule : tb_top
